/* File: src/sfd_map.svh */
// opcode and sequence constants for the flash command dispatcher
`ifndef SFD_MAP_SVH
`define SFD_MAP_SVH
`define SFD_BYTE_LAST 3'h7
`define SFD_SEQ_LAST 2'h3
`define SFD_PAGE_RD 8'hD2
`define SFD_ARR_LP 8'h01
`define SFD_ARR_LF 8'h03
`define SFD_ARR_HF 8'h0B
`define SFD_ARR_HF2 8'h1B
`define SFD_ARR_LEG 8'hE8
`define SFD_B1_RD_LF 8'hD1
`define SFD_B2_RD_LF 8'hD3
`define SFD_B1_RD_HF 8'hD4
`define SFD_B2_RD_HF 8'hD6
`define SFD_B1_WR 8'h84
`define SFD_B2_WR 8'h87
`define SFD_B1_PRG_E 8'h83
`define SFD_B2_PRG_E 8'h86
`define SFD_B1_PRG_N 8'h88
`define SFD_B2_PRG_N 8'h89
`define SFD_PT1_E 8'h82
`define SFD_PT2_E 8'h85
`define SFD_PT1_N 8'h02
`define SFD_PG_ERASE 8'h81
`define SFD_BLK_ERASE 8'h50
`define SFD_SEC_ERASE 8'h7C
`define SFD_SUSPEND 8'hB0
`define SFD_RESUME 8'hD0
`define SFD_RMW1 8'h58
`define SFD_RMW2 8'h59
`define SFD_XFER1 8'h53
`define SFD_XFER2 8'h55
`define SFD_CMP1 8'h60
`define SFD_CMP2 8'h61
`define SFD_PROT_RD 8'h32
`define SFD_LOCK_RD 8'h35
`define SFD_SECR_RD 8'h77
`define SFD_DPD 8'hB9
`define SFD_DPD_EXIT 8'hAB
`define SFD_UDPD 8'h79
`define SFD_STATUS 8'hD7
`define SFD_ID 8'h9F
`define SFD_CE_1 8'hC7
`define SFD_CE_2 8'h94
`define SFD_CE_3 8'h80
`define SFD_CE_4 8'h9A
`define SFD_PR_1 8'h3D
`define SFD_PR_2 8'h2A
`define SFD_PR_3 8'h7F
`define SFD_PR_EN 8'hA9
`define SFD_PR_DIS 8'h9A
`define SFD_PR_ERA 8'hCF
`define SFD_PR_PRG 8'hFC
`define SFD_LOCKDN 8'h30
`define SFD_CFG_3 8'h80
`define SFD_CFG_BIN 8'hA6
`define SFD_CFG_STD 8'hA7
`define SFD_FRZ_1 8'h34
`define SFD_FRZ_2 8'h55
`define SFD_FRZ_3 8'hAA
`define SFD_FRZ_4 8'h40
`define SFD_SECP_1 8'h9B
`define SFD_RST_1 8'hF0
`define SFD_ZERO 8'h00
`endif

/* File: src/sfd_pkg.sv */
// types shared by the flash command dispatcher
package sfd_pkg;
	typedef enum logic [5:0] {
		CMD_NONE, CMD_PAGE_RD, CMD_ARR_LP, CMD_ARR_LF, CMD_ARR_HF, CMD_ARR_LEG,
		CMD_BUF_RD_LF, CMD_BUF_RD_HF, CMD_PROT_RD, CMD_LOCK_RD, CMD_SECR_RD,
		CMD_BUF_WR, CMD_BUF_PRG_E, CMD_BUF_PRG_N, CMD_PT_PRG_E, CMD_PT_PRG_N,
		CMD_PG_ERASE, CMD_BLK_ERASE, CMD_SEC_ERASE, CMD_CHIP_ERASE, CMD_SUSPEND,
		CMD_RESUME, CMD_RMW, CMD_XFER, CMD_CMP, CMD_DPD, CMD_DPD_EXIT, CMD_UDPD,
		CMD_STATUS, CMD_ID, CMD_PROT_EN, CMD_PROT_DIS, CMD_PROT_ERA, CMD_PROT_PRG,
		CMD_LOCKDN, CMD_FREEZE, CMD_SECR_PRG, CMD_PG_BIN, CMD_PG_STD, CMD_SW_RESET
	} sfd_cmd_type;
	typedef enum logic [2:0] {GRP_NONE, GRP_A, GRP_B, GRP_C, GRP_D, GRP_X} sfd_grp_type;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_SEQ = 3'b001,
		S_PASS = 3'b010,
		S_DROP = 3'b011,
		S_RST = 3'b100
	} sfd_st_type;
	typedef struct packed {
		sfd_cmd_type cmd;
		sfd_grp_type grp;
		logic bsel;
		logic seq;
	} sfd_cls_type;
	typedef struct packed {
		logic [2:0] cnt;
		logic [7:0] sh;
		logic frame;
		logic bv;
		logic [7:0] bd;
		logic fe;
		logic al;
	} sfd_rx_type;
	typedef struct packed {
		sfd_st_type st;
		logic [1:0] n;
		logic [2:0][7:0] seq;
		sfd_cmd_type cmd;
		sfd_grp_type grp;
		logic bsel;
		logic valid;
		logic rej;
		logic rd;
		logic susp;
		sfd_grp_type last;
		logic obuf;
		logic can_susp;
	} sfd_core_type;
endpackage

/* File: src/sfd_byte_if.sv */
// byte stream from the serial shifter to the decoder
`timescale 1ns/10ps
interface sfd_byte_if;
	logic byte_valid;
	logic [7:0] byte_data;
	logic frame;
	logic frame_end;
	logic aligned;
	modport src (output byte_valid, output byte_data, output frame, output frame_end, output aligned);
	modport snk (input byte_valid, input byte_data, input frame, input frame_end, input aligned);
endinterface

/* File: src/sfd_rx_shift.sv */
// serial to byte shifter, msb first, framed by chip select
`timescale 1ns/10ps
`include "sfd_map.svh"
module sfd_rx_shift (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic bit_strobe,
	input wire logic bit_in,
	sfd_byte_if.src rx
);
	import sfd_pkg::*;
	sfd_rx_type q;
	sfd_rx_type d;

	always_comb
	begin
		d = q;
		d.bv = 1'b0;
		d.fe = 1'b0;
		if (!cs_n)
		begin
			d.frame = 1'b1;
			if (bit_strobe)
			begin
				d.sh = {q.sh[6:0], bit_in};
				d.cnt = q.cnt + 3'h1;
				if (q.cnt == `SFD_BYTE_LAST)
				begin
					d.bv = 1'b1;
					d.bd = {q.sh[6:0], bit_in};
				end
			end
		end
		else
		begin
			// alignment is caught as the frame closes, before the count clears
			d.fe = q.frame;
			d.al = q.cnt == 3'h0;
			d.frame = 1'b0;
			d.cnt = 3'h0;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			q <= '0;
		else
			q <= d;
	end

	assign rx.byte_valid = q.bv;
	assign rx.byte_data = q.bd;
	assign rx.frame = q.frame;
	assign rx.frame_end = q.fe;
	assign rx.aligned = q.al;
endmodule

/* File: src/sfd_opcode_lut.sv */
// first opcode byte to command, group and buffer
`timescale 1ns/10ps
`include "sfd_map.svh"
module sfd_opcode_lut (
	input wire logic [7:0] opcode,
	output sfd_pkg::sfd_cls_type cls
);
	import sfd_pkg::*;

	always_comb
	begin
		case (opcode)
			`SFD_PAGE_RD: cls = '{CMD_PAGE_RD, GRP_A, 1'b0, 1'b0};
			`SFD_ARR_LP: cls = '{CMD_ARR_LP, GRP_A, 1'b0, 1'b0};
			`SFD_ARR_LF: cls = '{CMD_ARR_LF, GRP_A, 1'b0, 1'b0};
			`SFD_ARR_HF: cls = '{CMD_ARR_HF, GRP_A, 1'b0, 1'b0};
			`SFD_ARR_HF2: cls = '{CMD_ARR_HF, GRP_A, 1'b0, 1'b0};
			`SFD_ARR_LEG: cls = '{CMD_ARR_LEG, GRP_A, 1'b0, 1'b0};
			`SFD_B1_RD_LF: cls = '{CMD_BUF_RD_LF, GRP_A, 1'b0, 1'b0};
			`SFD_B2_RD_LF: cls = '{CMD_BUF_RD_LF, GRP_A, 1'b1, 1'b0};
			`SFD_B1_RD_HF: cls = '{CMD_BUF_RD_HF, GRP_A, 1'b0, 1'b0};
			`SFD_B2_RD_HF: cls = '{CMD_BUF_RD_HF, GRP_A, 1'b1, 1'b0};
			`SFD_PROT_RD: cls = '{CMD_PROT_RD, GRP_A, 1'b0, 1'b0};
			`SFD_LOCK_RD: cls = '{CMD_LOCK_RD, GRP_A, 1'b0, 1'b0};
			`SFD_SECR_RD: cls = '{CMD_SECR_RD, GRP_A, 1'b0, 1'b0};
			`SFD_B1_WR: cls = '{CMD_BUF_WR, GRP_C, 1'b0, 1'b0};
			`SFD_B2_WR: cls = '{CMD_BUF_WR, GRP_C, 1'b1, 1'b0};
			`SFD_B1_PRG_E: cls = '{CMD_BUF_PRG_E, GRP_B, 1'b0, 1'b0};
			`SFD_B2_PRG_E: cls = '{CMD_BUF_PRG_E, GRP_B, 1'b1, 1'b0};
			`SFD_B1_PRG_N: cls = '{CMD_BUF_PRG_N, GRP_B, 1'b0, 1'b0};
			`SFD_B2_PRG_N: cls = '{CMD_BUF_PRG_N, GRP_B, 1'b1, 1'b0};
			`SFD_PT1_E: cls = '{CMD_PT_PRG_E, GRP_B, 1'b0, 1'b0};
			`SFD_PT2_E: cls = '{CMD_PT_PRG_E, GRP_B, 1'b1, 1'b0};
			`SFD_PT1_N: cls = '{CMD_PT_PRG_N, GRP_B, 1'b0, 1'b0};
			`SFD_PG_ERASE: cls = '{CMD_PG_ERASE, GRP_B, 1'b0, 1'b0};
			`SFD_BLK_ERASE: cls = '{CMD_BLK_ERASE, GRP_B, 1'b0, 1'b0};
			`SFD_SEC_ERASE: cls = '{CMD_SEC_ERASE, GRP_B, 1'b0, 1'b0};
			`SFD_SUSPEND: cls = '{CMD_SUSPEND, GRP_X, 1'b0, 1'b0};
			`SFD_RESUME: cls = '{CMD_RESUME, GRP_X, 1'b0, 1'b0};
			`SFD_RMW1: cls = '{CMD_RMW, GRP_B, 1'b0, 1'b0};
			`SFD_RMW2: cls = '{CMD_RMW, GRP_B, 1'b1, 1'b0};
			`SFD_XFER1: cls = '{CMD_XFER, GRP_B, 1'b0, 1'b0};
			`SFD_XFER2: cls = '{CMD_XFER, GRP_B, 1'b1, 1'b0};
			`SFD_CMP1: cls = '{CMD_CMP, GRP_B, 1'b0, 1'b0};
			`SFD_CMP2: cls = '{CMD_CMP, GRP_B, 1'b1, 1'b0};
			`SFD_DPD: cls = '{CMD_DPD, GRP_X, 1'b0, 1'b0};
			`SFD_DPD_EXIT: cls = '{CMD_DPD_EXIT, GRP_X, 1'b0, 1'b0};
			`SFD_UDPD: cls = '{CMD_UDPD, GRP_X, 1'b0, 1'b0};
			`SFD_STATUS: cls = '{CMD_STATUS, GRP_C, 1'b0, 1'b0};
			`SFD_ID: cls = '{CMD_ID, GRP_C, 1'b0, 1'b0};
			`SFD_CE_1: cls = '{CMD_NONE, GRP_NONE, 1'b0, 1'b1};
			`SFD_PR_1: cls = '{CMD_NONE, GRP_NONE, 1'b0, 1'b1};
			`SFD_FRZ_1: cls = '{CMD_NONE, GRP_NONE, 1'b0, 1'b1};
			`SFD_SECP_1: cls = '{CMD_NONE, GRP_NONE, 1'b0, 1'b1};
			`SFD_RST_1: cls = '{CMD_NONE, GRP_NONE, 1'b0, 1'b1};
			default: cls = '{CMD_NONE, GRP_NONE, 1'b0, 1'b0};
		endcase
	end
endmodule

/* File: src/sfd_dispatch.sv */
// command decoder and concurrency gate for the serial flash
`timescale 1ns/10ps
`include "sfd_map.svh"
module sfd_dispatch (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic bit_strobe,
	input wire logic bit_in,
	input wire logic op_busy,
	output logic cmd_valid,
	output logic cmd_reject,
	output sfd_pkg::sfd_cmd_type cmd_code,
	output sfd_pkg::sfd_grp_type cmd_group,
	output logic cmd_buf,
	output logic read_busy,
	output logic suspended
);
	import sfd_pkg::*;
	sfd_core_type q;
	sfd_core_type d;
	sfd_cls_type cls;
	logic busy_b;
	logic busy_d;
	sfd_byte_if rx ();

	sfd_rx_shift u_rx (
		.clk(clk),
		.resetn(resetn),
		.cs_n(cs_n),
		.bit_strobe(bit_strobe),
		.bit_in(bit_in),
		.rx(rx)
	);

	sfd_opcode_lut u_lut (
		.opcode(rx.byte_data),
		.cls(cls)
	);

	// op_busy only says the array is self-timing; which group owns it is
	// remembered from the last long operation dispatched here
	assign busy_b = op_busy && q.last == GRP_B && !q.susp;
	assign busy_d = op_busy && q.last == GRP_D;

	function automatic sfd_cmd_type seq_cmd(logic [2:0][7:0] s, logic [7:0] b);
		seq_cmd = CMD_NONE;
		if (s[0] == `SFD_CE_1 && s[1] == `SFD_CE_2 && s[2] == `SFD_CE_3 && b == `SFD_CE_4)
			seq_cmd = CMD_CHIP_ERASE;
		if (s[0] == `SFD_PR_1 && s[1] == `SFD_PR_2 && s[2] == `SFD_PR_3)
		begin
			case (b)
				`SFD_PR_EN: seq_cmd = CMD_PROT_EN;
				`SFD_PR_DIS: seq_cmd = CMD_PROT_DIS;
				`SFD_PR_ERA: seq_cmd = CMD_PROT_ERA;
				`SFD_PR_PRG: seq_cmd = CMD_PROT_PRG;
				`SFD_LOCKDN: seq_cmd = CMD_LOCKDN;
				default: seq_cmd = CMD_NONE;
			endcase
		end
		if (s[0] == `SFD_PR_1 && s[1] == `SFD_PR_2 && s[2] == `SFD_CFG_3)
		begin
			case (b)
				`SFD_CFG_BIN: seq_cmd = CMD_PG_BIN;
				`SFD_CFG_STD: seq_cmd = CMD_PG_STD;
				default: seq_cmd = CMD_NONE;
			endcase
		end
		if (s[0] == `SFD_FRZ_1 && s[1] == `SFD_FRZ_2 && s[2] == `SFD_FRZ_3 && b == `SFD_FRZ_4)
			seq_cmd = CMD_FREEZE;
		if (s[0] == `SFD_SECP_1 && s[1] == `SFD_ZERO && s[2] == `SFD_ZERO && b == `SFD_ZERO)
			seq_cmd = CMD_SECR_PRG;
		if (s[0] == `SFD_RST_1 && s[1] == `SFD_ZERO && s[2] == `SFD_ZERO && b == `SFD_ZERO)
			seq_cmd = CMD_SW_RESET;
	endfunction

	function automatic logic gate(sfd_cmd_type c, sfd_grp_type g, logic b);
		logic other_buf;
		other_buf = !(c == CMD_BUF_WR && b == q.obuf);
		if (busy_d)
			gate = c == CMD_STATUS;
		else if (q.susp)
			gate = g == GRP_A || (g == GRP_C && other_buf) || c == CMD_RESUME || c == CMD_SW_RESET;
		else if (busy_b)
			gate = (g == GRP_C && other_buf) || (c == CMD_SUSPEND && q.can_susp) || c == CMD_SW_RESET;
		else
			gate = c != CMD_SUSPEND && c != CMD_RESUME;
	endfunction

	always_comb
	begin
		sfd_cmd_type c;
		sfd_grp_type g;
		logic b;
		logic want;
		logic fire;
		c = CMD_NONE;
		g = GRP_NONE;
		b = 1'b0;
		want = 1'b0;
		fire = 1'b0;
		d = q;
		d.valid = 1'b0;
		d.rej = 1'b0;
		case (q.st)
			S_IDLE:
			begin
				if (rx.byte_valid && cls.seq)
				begin
					d.st = S_SEQ;
					d.seq[0] = rx.byte_data;
					d.n = 2'h1;
				end
				else if (rx.byte_valid)
				begin
					c = cls.cmd;
					g = cls.grp;
					b = cls.bsel;
					want = 1'b1;
				end
			end
			S_SEQ:
			begin
				if (rx.byte_valid && q.n != `SFD_SEQ_LAST)
				begin
					d.seq[q.n] = rx.byte_data;
					d.n = q.n + 2'h1;
				end
				else if (rx.byte_valid)
				begin
					c = seq_cmd(q.seq, rx.byte_data);
					g = c == CMD_CHIP_ERASE ? GRP_B : GRP_D;
					// reset waits for the frame to close on a byte boundary
					if (c == CMD_SW_RESET)
						d.st = S_RST;
					else
						want = 1'b1;
				end
			end
			default:
			begin
				d.st = q.st;
			end
		endcase
		if (rx.frame_end && q.st == S_RST && rx.aligned)
		begin
			c = CMD_SW_RESET;
			g = GRP_X;
			want = 1'b1;
		end
		if (want)
		begin
			if (c == CMD_NONE)
				d.st = S_DROP;
			else if (gate(c, g, b))
			begin
				fire = 1'b1;
				d.st = S_PASS;
			end
			else
			begin
				d.rej = 1'b1;
				d.st = S_DROP;
			end
		end
		if (rx.frame_end)
		begin
			d.st = S_IDLE;
			d.n = 2'h0;
			d.rd = 1'b0;
		end
		if (fire)
		begin
			d.valid = 1'b1;
			d.cmd = c;
			d.grp = g;
			d.bsel = b;
			d.rd = g == GRP_A;
			if (g == GRP_B || g == GRP_D)
			begin
				d.last = g;
				d.obuf = b;
				d.can_susp = !(c == CMD_XFER || c == CMD_CMP || c == CMD_RMW);
			end
			if (c == CMD_SUSPEND)
				d.susp = 1'b1;
			if (c == CMD_RESUME || c == CMD_SW_RESET)
				d.susp = 1'b0;
			if (c == CMD_SW_RESET)
				d.last = GRP_NONE;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			q <= '0;
		else
			q <= d;
	end

	assign cmd_valid = q.valid;
	assign cmd_reject = q.rej;
	assign cmd_code = q.cmd;
	assign cmd_group = q.grp;
	assign cmd_buf = q.bsel;
	assign read_busy = q.rd;
	assign suspended = q.susp;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	drop_hold_a: assert property (q.st == S_DROP && !rx.frame_end |=> q.st == S_DROP)
		else $error("ignored frame left drop state early");
	reject_drop_a: assert property (cmd_reject |-> q.st == S_DROP && !cmd_valid)
		else $error("rejected command not dropped");
	read_hold_a: assert property (read_busy && !rx.frame_end |=> read_busy)
		else $error("read busy fell inside frame");
	status_only_a: assert property (rx.byte_valid && q.st == S_IDLE && busy_d && !cls.seq
		&& rx.byte_data != `SFD_STATUS |=> !cmd_valid)
		else $error("command dispatched during protection busy");
	status_ok_a: assert property (rx.byte_valid && q.st == S_IDLE && rx.byte_data == `SFD_STATUS
		|=> cmd_valid && cmd_code == CMD_STATUS && cmd_group == GRP_C)
		else $error("status read not dispatched");
	c_in_b_a: assert property (rx.byte_valid && q.st == S_IDLE && busy_b && rx.byte_data == `SFD_ID
		|=> cmd_valid && cmd_code == CMD_ID)
		else $error("id read refused while self-timing");
	buf_other_a: assert property (cmd_valid && cmd_code == CMD_BUF_WR && $past(op_busy)
		&& $past(q.last) == GRP_B |-> cmd_buf != q.obuf)
		else $error("buffer write hit busy buffer");
	suspend_ok_a: assert property (cmd_valid && cmd_code == CMD_SUSPEND
		|-> $past(q.can_susp) && suspended)
		else $error("suspend of non suspendable operation");
	read_susp_a: assert property (rx.byte_valid && q.st == S_IDLE && q.susp && !busy_d
		&& cls.grp == GRP_A |=> cmd_valid && cmd_group == GRP_A)
		else $error("read refused while suspended");
	page_rd_a: assert property (rx.byte_valid && q.st == S_IDLE && !op_busy && !q.susp
		&& rx.byte_data == `SFD_PAGE_RD |=> cmd_valid && cmd_code == CMD_PAGE_RD)
		else $error("page read not decoded");
	chip_erase_a: assert property (cmd_valid && cmd_code == CMD_CHIP_ERASE
		|-> q.seq[0] == `SFD_CE_1 && q.seq[2] == `SFD_CE_3)
		else $error("chip erase without full sequence");
	sw_reset_a: assert property (cmd_valid && cmd_code == CMD_SW_RESET
		|-> $past(rx.frame_end) && $past(rx.aligned) && $past(q.st) == S_RST)
		else $error("software reset outside aligned frame end");

	seq_cover: cover property (q.st == S_SEQ ##1 q.st == S_SEQ [*2] ##1 cmd_valid);
	susp_cover: cover property (cmd_valid && cmd_code == CMD_SUSPEND ##[1:200] cmd_valid && cmd_group == GRP_A);
	reject_cover: cover property (busy_b ##0 cmd_reject);
	reset_cover: cover property (cmd_valid && cmd_code == CMD_SW_RESET);
endmodule

/* File: testbench/sfd_host_model.sv */
// spi host model that clocks command frames into the dispatcher
`timescale 1ns/10ps
module sfd_host_model (
	input wire logic clk,
	output logic cs_n,
	output logic bit_strobe,
	output logic bit_in
);
	int cyc;
	int t_s;
	initial
	begin
		cs_n = 1'h1;
		bit_strobe = 1'h0;
		bit_in = 1'h0;
		cyc = 0;
		t_s = 0;
	end
	// idle line toggles so a stray sample never reads a stable guess
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cs_n)
			bit_in <= ~bit_in;
	end
	// gap idle cycles between bits lets the host run fast or slow
	task automatic send(input logic [31:0] b, input int nb, input int gap);
		int k;
		int g;
		@(posedge clk);
		cs_n <= 1'h0;
		for (k = 0; k < nb; k++)
		begin
			@(posedge clk);
			bit_strobe <= 1'h1;
			bit_in <= b[31-k];
			t_s = cyc;
			for (g = 0; g < gap; g++)
			begin
				@(posedge clk);
				bit_strobe <= 1'h0;
				bit_in <= ~b[31-k];
			end
		end
		@(posedge clk);
		bit_strobe <= 1'h0;
		bit_in <= ~bit_in;
	endtask
	// one command per frame: nothing new starts before chip select rises
	task automatic stop();
		@(posedge clk);
		cs_n <= 1'h1;
	endtask
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the flash command dispatcher
`timescale 1ns/10ps
module tb_top;
	import sfd_pkg::*;
	typedef struct {logic [31:0] b; int nb; logic [1:0] vr; sfd_cmd_type c; sfd_grp_type g; logic [1:0] bb;} sfd_row_type;
	logic clk;
	logic resetn;
	logic op_busy;
	logic cs_n;
	logic bit_strobe;
	logic bit_in;
	logic cmd_valid;
	logic cmd_reject;
	logic cmd_buf;
	logic read_busy;
	logic suspended;
	sfd_cmd_type cmd_code;
	sfd_grp_type cmd_group;
	int n_v;
	int n_r;
	int nv0;
	int nr0;
	logic got_b;
	sfd_cmd_type got_c;
	sfd_grp_type got_g;
	int t_v;
	int n_mismatch;
	int comparisons;
	int i;
	// vr: 2 accepted, 1 refused, 0 silent; bb: 2 buffer one, 3 buffer two, 0 unchecked
	sfd_row_type rows [53] = '{
		'{32'hD200_0000, 8, 2'h2, CMD_PAGE_RD, GRP_A, 2'h0}, '{32'h0100_0000, 8, 2'h2, CMD_ARR_LP, GRP_A, 2'h0},
		'{32'h0300_0000, 8, 2'h2, CMD_ARR_LF, GRP_A, 2'h0}, '{32'h0B00_0000, 8, 2'h2, CMD_ARR_HF, GRP_A, 2'h0},
		'{32'h1B00_0000, 8, 2'h2, CMD_ARR_HF, GRP_A, 2'h0}, '{32'hE800_0000, 8, 2'h2, CMD_ARR_LEG, GRP_A, 2'h0},
		'{32'hD100_0000, 8, 2'h2, CMD_BUF_RD_LF, GRP_A, 2'h2}, '{32'hD300_0000, 8, 2'h2, CMD_BUF_RD_LF, GRP_A, 2'h3},
		'{32'hD400_0000, 8, 2'h2, CMD_BUF_RD_HF, GRP_A, 2'h2}, '{32'hD600_0000, 8, 2'h2, CMD_BUF_RD_HF, GRP_A, 2'h3},
		'{32'h8400_0000, 8, 2'h2, CMD_BUF_WR, GRP_C, 2'h2}, '{32'h8700_0000, 8, 2'h2, CMD_BUF_WR, GRP_C, 2'h3},
		'{32'h8300_0000, 8, 2'h2, CMD_BUF_PRG_E, GRP_B, 2'h2}, '{32'h8600_0000, 8, 2'h2, CMD_BUF_PRG_E, GRP_B, 2'h3},
		'{32'h8800_0000, 8, 2'h2, CMD_BUF_PRG_N, GRP_B, 2'h2}, '{32'h8900_0000, 8, 2'h2, CMD_BUF_PRG_N, GRP_B, 2'h3},
		'{32'h8200_0000, 8, 2'h2, CMD_PT_PRG_E, GRP_B, 2'h2}, '{32'h8500_0000, 8, 2'h2, CMD_PT_PRG_E, GRP_B, 2'h3},
		'{32'h0200_0000, 8, 2'h2, CMD_PT_PRG_N, GRP_B, 2'h2}, '{32'h8100_0000, 8, 2'h2, CMD_PG_ERASE, GRP_B, 2'h0},
		'{32'h5000_0000, 8, 2'h2, CMD_BLK_ERASE, GRP_B, 2'h0}, '{32'h7C00_0000, 8, 2'h2, CMD_SEC_ERASE, GRP_B, 2'h0},
		'{32'hC794_809A, 32, 2'h2, CMD_CHIP_ERASE, GRP_B, 2'h0}, '{32'h5800_0000, 8, 2'h2, CMD_RMW, GRP_B, 2'h2},
		'{32'h5900_0000, 8, 2'h2, CMD_RMW, GRP_B, 2'h3}, '{32'h5300_0000, 8, 2'h2, CMD_XFER, GRP_B, 2'h2},
		'{32'h5500_0000, 8, 2'h2, CMD_XFER, GRP_B, 2'h3}, '{32'h6000_0000, 8, 2'h2, CMD_CMP, GRP_B, 2'h2},
		'{32'h6100_0000, 8, 2'h2, CMD_CMP, GRP_B, 2'h3}, '{32'h3200_0000, 8, 2'h2, CMD_PROT_RD, GRP_A, 2'h0},
		'{32'h3500_0000, 8, 2'h2, CMD_LOCK_RD, GRP_A, 2'h0}, '{32'h7700_0000, 8, 2'h2, CMD_SECR_RD, GRP_A, 2'h0},
		'{32'h3D2A_7FA9, 32, 2'h2, CMD_PROT_EN, GRP_D, 2'h0}, '{32'h3D2A_7F9A, 32, 2'h2, CMD_PROT_DIS, GRP_D, 2'h0},
		'{32'h3D2A_7FCF, 32, 2'h2, CMD_PROT_ERA, GRP_D, 2'h0}, '{32'h3D2A_7FFC, 32, 2'h2, CMD_PROT_PRG, GRP_D, 2'h0},
		'{32'h3D2A_7F30, 32, 2'h2, CMD_LOCKDN, GRP_D, 2'h0}, '{32'h3455_AA40, 32, 2'h2, CMD_FREEZE, GRP_D, 2'h0},
		'{32'h9B00_0000, 32, 2'h2, CMD_SECR_PRG, GRP_D, 2'h0}, '{32'h3D2A_80A6, 32, 2'h2, CMD_PG_BIN, GRP_D, 2'h0},
		'{32'h3D2A_80A7, 32, 2'h2, CMD_PG_STD, GRP_D, 2'h0}, '{32'h9F00_0000, 8, 2'h2, CMD_ID, GRP_C, 2'h0},
		'{32'hD700_0000, 8, 2'h2, CMD_STATUS, GRP_C, 2'h0}, '{32'hB900_0000, 8, 2'h2, CMD_DPD, GRP_X, 2'h0},
		'{32'hAB00_0000, 8, 2'h2, CMD_DPD_EXIT, GRP_X, 2'h0}, '{32'h7900_0000, 8, 2'h2, CMD_UDPD, GRP_X, 2'h0},
		'{32'hF000_0000, 32, 2'h2, CMD_SW_RESET, GRP_X, 2'h0}, '{32'hB000_0000, 8, 2'h1, CMD_NONE, GRP_NONE, 2'h0},
		'{32'hD000_0000, 8, 2'h1, CMD_NONE, GRP_NONE, 2'h0}, '{32'h5400_0000, 8, 2'h0, CMD_NONE, GRP_NONE, 2'h0},
		'{32'hC794_809B, 32, 2'h0, CMD_NONE, GRP_NONE, 2'h0}, '{32'h3D2A_7F00, 32, 2'h0, CMD_NONE, GRP_NONE, 2'h0},
		'{32'hF000_0001, 32, 2'h0, CMD_NONE, GRP_NONE, 2'h0}};
	sfd_dispatch dut (.clk(clk), .resetn(resetn), .cs_n(cs_n), .bit_strobe(bit_strobe), .bit_in(bit_in),
		.op_busy(op_busy), .cmd_valid(cmd_valid), .cmd_reject(cmd_reject), .cmd_code(cmd_code),
		.cmd_group(cmd_group), .cmd_buf(cmd_buf), .read_busy(read_busy), .suspended(suspended));
	sfd_host_model host (.clk(clk), .cs_n(cs_n), .bit_strobe(bit_strobe), .bit_in(bit_in));
	initial
	begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	// pulses last one cycle, so they are latched here and judged after the frame
	always @(posedge clk)
	begin
		if (cmd_valid === 1'h1)
		begin
			n_v <= n_v + 1;
			got_c <= cmd_code;
			got_g <= cmd_group;
			got_b <= cmd_buf;
			t_v <= host.cyc;
		end
		if (cmd_reject === 1'h1)
			n_r <= n_r + 1;
		if (host.cyc > 20000)
		begin
			n_mismatch++;
			$display("ERROR %0t: timeout", $time);
			results();
		end
	end
	task automatic results();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic ck(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'h1)
		begin
			n_mismatch++;
			$display("ERROR %0t: %s", $time, m);
		end
	endtask
	task automatic fc(input logic [31:0] b, input int nb, input int gap, input logic [1:0] vr, input sfd_cmd_type c,
		input sfd_grp_type g, input logic [1:0] bb);
		int v0;
		int r0;
		v0 = n_v;
		r0 = n_r;
		host.send(b, nb, gap);
		host.stop();
		repeat (5) @(posedge clk);
		#1;
		// pulses are counted, so a doubled pulse fails as well as a missing one
		ck(n_v - v0 == vr[1] && n_r - r0 == vr[0] && (!vr[1] || (got_c === c && got_g === g))
			&& (!bb[1] || got_b === bb[0]), $sformatf("frame %h gave code %0d", b, got_c));
	endtask
	task automatic fr(input int k);
		fc(rows[k].b, rows[k].nb, k % 3, rows[k].vr, rows[k].c, rows[k].g, rows[k].bb);
	endtask
	task automatic busy(input logic v);
		@(posedge clk);
		op_busy <= v;
	endtask
	initial
	begin
		resetn = 1'h0;
		op_busy = 1'h0;
		n_mismatch = 0;
		comparisons = 0;
		repeat (3) @(posedge clk);
		resetn <= 1'h1;
		@(posedge clk);
		#1;
		ck(cmd_valid === 1'h0 && cmd_reject === 1'h0 && suspended === 1'h0 && read_busy === 1'h0, "reset outputs");
		ck(cmd_code === CMD_NONE && cmd_group === GRP_NONE, "reset code");
		for (i = 0; i < 53; i++)
			fr(i);
		nv0 = n_v;
		host.send(32'hD200_0000, 8, 0);
		repeat (4) @(posedge clk);
		#1;
		ck(read_busy === 1'h1 && n_v - nv0 == 1, "read not running");
		// strobe is launched one edge before it is taken, the answer lands two edges later
		ck(t_v - host.t_s == 3, "answer latency");
		host.stop();
		repeat (5) @(posedge clk);
		#1;
		ck(read_busy === 1'h0, "read still running");
		fc(32'h8300_0000, 8, 1, 2'h2, CMD_BUF_PRG_E, GRP_B, 2'h2);
		busy(1'h1);
		fc(32'h8700_0000, 8, 1, 2'h2, CMD_BUF_WR, GRP_C, 2'h3);
		fc(32'h8400_0000, 8, 1, 2'h1, CMD_NONE, GRP_NONE, 2'h0);
		fc(32'hD700_0000, 8, 1, 2'h2, CMD_STATUS, GRP_C, 2'h0);
		fc(32'h9F00_0000, 8, 1, 2'h2, CMD_ID, GRP_C, 2'h0);
		fc(32'hD200_0000, 8, 1, 2'h1, CMD_NONE, GRP_NONE, 2'h0);
		fc(32'hB000_0000, 8, 1, 2'h2, CMD_SUSPEND, GRP_X, 2'h0);
		ck(suspended === 1'h1, "not suspended");
		fc(32'hD200_0000, 8, 1, 2'h2, CMD_PAGE_RD, GRP_A, 2'h0);
		fc(32'h3200_0000, 8, 1, 2'h2, CMD_PROT_RD, GRP_A, 2'h0);
		fc(32'hD600_0000, 8, 1, 2'h2, CMD_BUF_RD_HF, GRP_A, 2'h3);
		fc(32'h8400_0000, 8, 1, 2'h1, CMD_NONE, GRP_NONE, 2'h0);
		fc(32'hD000_0000, 8, 1, 2'h2, CMD_RESUME, GRP_X, 2'h0);
		ck(suspended === 1'h0, "still suspended");
		busy(1'h0);
		fc(32'h5300_0000, 8, 1, 2'h2, CMD_XFER, GRP_B, 2'h2);
		busy(1'h1);
		fc(32'hB000_0000, 8, 1, 2'h1, CMD_NONE, GRP_NONE, 2'h0);
		fc(32'hF000_0000, 32, 1, 2'h2, CMD_SW_RESET, GRP_X, 2'h0);
		busy(1'h0);
		fc(32'h3D2A_7FFC, 32, 1, 2'h2, CMD_PROT_PRG, GRP_D, 2'h0);
		busy(1'h1);
		fc(32'hD700_0000, 8, 1, 2'h2, CMD_STATUS, GRP_C, 2'h0);
		fc(32'h9F00_0000, 8, 1, 2'h1, CMD_NONE, GRP_NONE, 2'h0);
		fc(32'h8700_0000, 8, 1, 2'h1, CMD_NONE, GRP_NONE, 2'h0);
		busy(1'h0);
		nv0 = n_v;
		nr0 = n_r;
		host.send(32'hF000_0000, 32, 0);
		host.send(32'h0000_0000, 3, 0);
		host.stop();
		repeat (5) @(posedge clk);
		#1;
		ck(n_v == nv0 && n_r == nr0, "reset off byte boundary");
		fc(32'h8100_0000, 8, 1, 2'h2, CMD_PG_ERASE, GRP_B, 2'h0);
		busy(1'h1);
		fc(32'hB000_0000, 8, 1, 2'h2, CMD_SUSPEND, GRP_X, 2'h0);
		// reset in mid-run must drop the suspension with everything else
		@(posedge clk);
		resetn <= 1'h0;
		op_busy <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
		ck(suspended === 1'h0 && cmd_code === CMD_NONE, "mid-run reset");
		@(posedge clk);
		resetn <= 1'h1;
		fc(32'hD700_0000, 8, 2, 2'h2, CMD_STATUS, GRP_C, 2'h0);
		results();
	end
endmodule
